/* rtl/twrl_pkg.sv */
// twrl_pkg: constants shared by the three-wire register loader
package twrl_pkg;
	// frame layout: data field first (msb first), address field last
	localparam int TWRL_FRAME_BITS = 24;
	localparam int TWRL_ADDR_BITS = 4;
	localparam int TWRL_DATA_BITS = 20;
	localparam int TWRL_DATA_POS = 4;

	// register address codes
	localparam logic [3:0] TWRL_ADDR_RF_MAIN = 4'h0;
	localparam logic [3:0] TWRL_ADDR_RF_REF = 4'h1;
	localparam logic [3:0] TWRL_ADDR_IF_MAIN = 4'h2;
	localparam logic [3:0] TWRL_ADDR_IF_REF = 4'h3;
	localparam logic [3:0] TWRL_ADDR_OPERATING_CONTROL_REG = 4'h4;
	localparam logic [3:0] TWRL_ADDR_CONFIG = 4'h5;
	localparam logic [3:0] TWRL_ADDR_BIAS = 4'h6;
	localparam logic [3:0] TWRL_ADDR_TEST = 4'h7;

	// meaningful widths; data bits above these are don't-care
	localparam int TWRL_RF_MAIN_W = 18;
	localparam int TWRL_RF_REF_W = 13;
	localparam int TWRL_IF_MAIN_W = 14;
	localparam int TWRL_IF_REF_W = 11;
	localparam int TWRL_CTRL_W = 16;
	localparam int TWRL_TEST_W = 9;

	// reset values: the typical settings
	localparam logic [17:0] TWRL_RF_MAIN_RST = 18'h059d8;
	localparam logic [12:0] TWRL_RF_REF_RST = 13'h0180;
	localparam logic [13:0] TWRL_IF_MAIN_RST = 14'h12c0;
	localparam logic [10:0] TWRL_IF_REF_RST = 11'h180;
	localparam logic [15:0] TWRL_OPERATING_CONTROL_REG_RST = 16'h090f;
	localparam logic [15:0] TWRL_CONFIG_RST = 16'hd03f;
	localparam logic [15:0] TWRL_BIAS_RST = 16'h0000;
	localparam logic [8:0] TWRL_TEST_RST = 9'h000;

	// field positions inside the control registers
	localparam int TWRL_OP_POWER_DOWN_POS = 0;
	localparam int TWRL_OP_LO_BUF_EN_POS = 1;
	localparam int TWRL_CFG_IF_PUMP_POS = 0;
	localparam int TWRL_CFG_RF_PUMP_POS = 2;
	localparam int TWRL_CFG_IF_FAST_POS = 4;
	localparam int TWRL_CFG_RF_FAST1_POS = 5;
	localparam int TWRL_CFG_RF_FAST2_POS = 6;
	localparam int TWRL_BIAS_HP_POS = 0;

	// charge-pump current code width and the turbo (maximum) code
	localparam int TWRL_PUMP_W = 2;
	localparam logic [1:0] TWRL_PUMP_MAX = 2'h3;
endpackage : twrl_pkg

/* rtl/twrl_sync.sv */
// twrl_sync: two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/100ps
module twrl_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// asynchronous inputs and their synchronised copies
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} twrl_sync_state_t;

	twrl_sync_state_t state;
	twrl_sync_state_t next_state;

	// stage1 is read only by stage2, never by logic
	always_comb begin
		next_state.stage1 = async_in;
		next_state.stage2 = state.stage1;
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			// both stages reset to the idle pin level, so release shows no false edge
			state.stage1 <= RESET_VALUE;
			state.stage2 <= RESET_VALUE;
		end else begin
			state <= next_state;
		end
	end

	assign sync_out = state.stage2;
endmodule : twrl_sync

/* rtl/twrl_hold.sv */
// twrl_hold: one loadable program register with a reset value
`timescale 1ns/100ps
module twrl_hold #(
	parameter int WIDTH = 16,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// load strobe and data
	input wire logic load,
	input wire logic [WIDTH-1:0] load_data,
	output logic [WIDTH-1:0] value
);
	typedef struct packed {
		logic [WIDTH-1:0] held;
	} twrl_hold_state_t;

	twrl_hold_state_t state;
	twrl_hold_state_t next_state;

	// nothing but sys_rst clears it, so power-down never loses contents
	always_comb begin
		next_state = state;
		if (load) begin
			next_state.held = load_data;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state.held <= RESET_VALUE;
		end else begin
			state <= next_state;
		end
	end

	assign value = state.held;
endmodule : twrl_hold

/* rtl/twrl_loader.sv */
// twrl_loader: three-wire serial register loader with control decoding
//
// Behaviour
// - eight registers, each loaded by 24-bit word
// - address in low 4 bits, data above
// - don't-care data bits are ignored
// - shift one bit per clock rise, select low
// - select rising loads the addressed register
// - rf dividers set rf pll ratios
// - if dividers set if pll ratios
// - serial loading works during shutdown
// - power down by bit zero or pin low
// - contents survive either shutdown
// - lo output enabled only when bit set
// - fast-lock bit gives turbo pump current
// - after lock, pump uses programmed current
// - high-power select chooses bias mode
// - address codes map to the eight registers
`timescale 1ns/100ps
module twrl_loader (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// serial port pins
	input wire logic serial_clk,
	input wire logic serial_cs_n,
	input wire logic serial_data,
	// pins and analog status
	input wire logic power_down_pin_n,
	input wire logic if_pll_locked,
	input wire logic rf_pll_locked,
	// divider ratios
	output logic [twrl_pkg::TWRL_RF_MAIN_W-1:0] rf_main_divider,
	output logic [twrl_pkg::TWRL_RF_REF_W-1:0] rf_ref_divider,
	output logic [twrl_pkg::TWRL_IF_MAIN_W-1:0] if_main_divider,
	output logic [twrl_pkg::TWRL_IF_REF_W-1:0] if_ref_divider,
	// raw control registers
	output logic [twrl_pkg::TWRL_CTRL_W-1:0] operating_control_reg,
	output logic [twrl_pkg::TWRL_CTRL_W-1:0] config_reg,
	output logic [twrl_pkg::TWRL_CTRL_W-1:0] bias_current_reg,
	output logic [twrl_pkg::TWRL_TEST_W-1:0] test_reg,
	// decoded controls
	output logic device_power_down,
	output logic if_lo_out,
	output logic if_turbo,
	output logic rf_turbo,
	output logic [twrl_pkg::TWRL_PUMP_W-1:0] if_pump_current,
	output logic [twrl_pkg::TWRL_PUMP_W-1:0] rf_pump_current,
	output logic high_power_select,
	// one-cycle pulse per accepted word
	output logic word_loaded
);
	import twrl_pkg::*;

	typedef struct packed {
		logic sclk_prev;
		logic cs_n_prev;
		logic [TWRL_FRAME_BITS-1:0] shift;
		logic power_down;
		logic lo_out;
		logic if_turbo;
		logic rf_turbo;
		logic [TWRL_PUMP_W-1:0] if_pump;
		logic [TWRL_PUMP_W-1:0] rf_pump;
		logic high_power;
		logic loaded;
	} twrl_loader_state_t;

	twrl_loader_state_t state;
	twrl_loader_state_t next_state;

	logic sclk_s;
	logic cs_n_s;
	logic sdata_s;
	logic pd_pin_n_s;
	logic if_lock_s;
	logic rf_lock_s;
	logic sclk_rise;
	logic cs_rise;
	logic [TWRL_ADDR_BITS-1:0] word_addr;
	logic [TWRL_DATA_BITS-1:0] word_data;
	logic [7:0] load_sel;
	logic if_fast;
	logic rf_fast;

	// every pin is outside the clock domain; clock and data share the same delay
	twrl_sync #(
		.WIDTH(6),
		.RESET_VALUE(6'h34) // idle levels: clock, select and power-down pin high
	) u_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.async_in({serial_clk, serial_cs_n, serial_data,
			power_down_pin_n, if_pll_locked, rf_pll_locked}),
		.sync_out({sclk_s, cs_n_s, sdata_s, pd_pin_n_s, if_lock_s, rf_lock_s})
	);

	// edges found on the synchronised copies only
	assign sclk_rise = sclk_s & ~state.sclk_prev;
	assign cs_rise = cs_n_s & ~state.cs_n_prev;

	// low four bits are address, upper twenty are data
	assign word_addr = state.shift[TWRL_ADDR_BITS-1:0];
	assign word_data = state.shift[TWRL_FRAME_BITS-1:TWRL_DATA_POS];

	// address decode; codes 8..f select nothing
	always_comb begin
		load_sel = 8'h00;
		if (cs_rise) begin
			case (word_addr)
				TWRL_ADDR_RF_MAIN: load_sel = 8'h01;
				TWRL_ADDR_RF_REF: load_sel = 8'h02;
				TWRL_ADDR_IF_MAIN: load_sel = 8'h04;
				TWRL_ADDR_IF_REF: load_sel = 8'h08;
				TWRL_ADDR_OPERATING_CONTROL_REG: load_sel = 8'h10;
				TWRL_ADDR_CONFIG: load_sel = 8'h20;
				TWRL_ADDR_BIAS: load_sel = 8'h40;
				TWRL_ADDR_TEST: load_sel = 8'h80;
				default: load_sel = 8'h00;
			endcase
		end
	end

	// eight registers; each keeps only its meaningful low bits
	twrl_hold #(
		.WIDTH(TWRL_RF_MAIN_W),
		.RESET_VALUE(TWRL_RF_MAIN_RST)
	) u_rf_main (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.load(load_sel[0]),
		.load_data(word_data[TWRL_RF_MAIN_W-1:0]),
		.value(rf_main_divider)
	);

	twrl_hold #(
		.WIDTH(TWRL_RF_REF_W),
		.RESET_VALUE(TWRL_RF_REF_RST)
	) u_rf_ref (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.load(load_sel[1]),
		.load_data(word_data[TWRL_RF_REF_W-1:0]),
		.value(rf_ref_divider)
	);

	twrl_hold #(
		.WIDTH(TWRL_IF_MAIN_W),
		.RESET_VALUE(TWRL_IF_MAIN_RST)
	) u_if_main (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.load(load_sel[2]),
		.load_data(word_data[TWRL_IF_MAIN_W-1:0]),
		.value(if_main_divider)
	);

	twrl_hold #(
		.WIDTH(TWRL_IF_REF_W),
		.RESET_VALUE(TWRL_IF_REF_RST)
	) u_if_ref (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.load(load_sel[3]),
		.load_data(word_data[TWRL_IF_REF_W-1:0]),
		.value(if_ref_divider)
	);

	twrl_hold #(
		.WIDTH(TWRL_CTRL_W),
		.RESET_VALUE(TWRL_OPERATING_CONTROL_REG_RST)
	) u_operating_control_reg (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.load(load_sel[4]),
		.load_data(word_data[TWRL_CTRL_W-1:0]),
		.value(operating_control_reg)
	);

	twrl_hold #(
		.WIDTH(TWRL_CTRL_W),
		.RESET_VALUE(TWRL_CONFIG_RST)
	) u_config (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.load(load_sel[5]),
		.load_data(word_data[TWRL_CTRL_W-1:0]),
		.value(config_reg)
	);

	twrl_hold #(
		.WIDTH(TWRL_CTRL_W),
		.RESET_VALUE(TWRL_BIAS_RST)
	) u_bias (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.load(load_sel[6]),
		.load_data(word_data[TWRL_CTRL_W-1:0]),
		.value(bias_current_reg)
	);

	twrl_hold #(
		.WIDTH(TWRL_TEST_W),
		.RESET_VALUE(TWRL_TEST_RST)
	) u_test (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.load(load_sel[7]),
		.load_data(word_data[TWRL_TEST_W-1:0]),
		.value(test_reg)
	);

	// fast-lock requests from the configuration register
	assign if_fast = config_reg[TWRL_CFG_IF_FAST_POS];
	assign rf_fast = config_reg[TWRL_CFG_RF_FAST1_POS] | config_reg[TWRL_CFG_RF_FAST2_POS];

	// shifting, edge history and decoded controls
	always_comb begin
		next_state = state;
		next_state.sclk_prev = sclk_s;
		next_state.cs_n_prev = cs_n_s;
		// no power-down term here, so loading goes on in shutdown
		if (!cs_n_s && sclk_rise) begin
			next_state.shift = {state.shift[TWRL_FRAME_BITS-2:0], sdata_s};
		end
		next_state.loaded = |load_sel;
		// either source alone powers down; registers stay untouched
		next_state.power_down = ~operating_control_reg[TWRL_OP_POWER_DOWN_POS]
			| ~pd_pin_n_s;
		next_state.lo_out = operating_control_reg[TWRL_OP_LO_BUF_EN_POS];
		// turbo only while acquiring; lock status ends it
		next_state.if_turbo = if_fast & ~if_lock_s;
		next_state.rf_turbo = rf_fast & ~rf_lock_s;
		if (next_state.if_turbo) begin
			next_state.if_pump = TWRL_PUMP_MAX;
		end else begin
			next_state.if_pump = config_reg[TWRL_CFG_IF_PUMP_POS +: TWRL_PUMP_W];
		end
		if (next_state.rf_turbo) begin
			next_state.rf_pump = TWRL_PUMP_MAX;
		end else begin
			next_state.rf_pump = config_reg[TWRL_CFG_RF_PUMP_POS +: TWRL_PUMP_W];
		end
		next_state.high_power = bias_current_reg[TWRL_BIAS_HP_POS];
	end

	// prev flags reset high so a select already high at release is no edge
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state <= '0;
			state.sclk_prev <= 1'b1;
			state.cs_n_prev <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	// decoded outputs come straight from state flops
	assign device_power_down = state.power_down;
	assign if_lo_out = state.lo_out;
	assign if_turbo = state.if_turbo;
	assign rf_turbo = state.rf_turbo;
	assign if_pump_current = state.if_pump;
	assign rf_pump_current = state.rf_pump;
	assign high_power_select = state.high_power;
	assign word_loaded = state.loaded;
endmodule : twrl_loader

/* dv/twrl_host.sv */
// twrl_host: host-side driver of the three-wire serial port
`timescale 1ns/100ps
module twrl_host (
	// clock
	input wire logic clk_sys,
	// serial pins
	output logic serial_clk,
	output logic serial_cs_n,
	output logic serial_data
);
	// idle: clock and select stay high between frames
	initial begin
		serial_clk = 1'b1;
		serial_cs_n = 1'b1;
		serial_data = 1'b0;
	end
	// half of the 400 ns serial clock
	task automatic half;
		repeat (4) @(posedge clk_sys);
		#1;
	endtask : half
	// data changes with the falling clock so it is steady at the rise
	task automatic send(input logic [23:0] w);
		serial_cs_n = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			serial_clk = 1'b0;
			serial_data = w[i];
			half();
			serial_clk = 1'b1;
			half();
		end
		serial_cs_n = 1'b1;
		serial_data = ~serial_data; // data line flipped to the inverse of the last bit, still driven
		half();
		half();
	endtask : send
endmodule : twrl_host

/* dv/twrl_loader_assertions.sv */
// twrl_loader_assertions: port checker for the register loader
`timescale 1ns/100ps
module twrl_loader_assertions (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// pins
	input wire logic serial_cs_n,
	input wire logic power_down_pin_n,
	// registers
	input wire logic [17:0] rf_main_divider,
	input wire logic [15:0] operating_control_reg,
	input wire logic [15:0] config_reg,
	input wire logic [15:0] bias_current_reg,
	// decoded
	input wire logic device_power_down,
	input wire logic if_lo_out,
	input wire logic if_turbo,
	input wire logic rf_turbo,
	input wire logic [1:0] if_pump_current,
	input wire logic [1:0] rf_pump_current,
	input wire logic high_power_select,
	input wire logic word_loaded
);
	import twrl_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	a_load_one_wide: assert property (word_loaded |=> !word_loaded)
		else $error("load pulse too long");
	a_load_after_cs: assert property (word_loaded |-> $past(serial_cs_n, 2))
		else $error("load without select rise");
	a_regs_need_load: assert property ($changed({rf_main_divider,
		operating_control_reg, config_reg, bias_current_reg}) |-> word_loaded)
		else $error("register changed without load");
	a_pd_by_pin: assert property (!power_down_pin_n [*5] |-> device_power_down)
		else $error("pin did not power down");
	a_pd_by_bit: assert property (!operating_control_reg[0] [*3] |-> device_power_down)
		else $error("bit did not power down");
	a_pd_neither: assert property ((power_down_pin_n && operating_control_reg[0])
		[*5] |-> !device_power_down)
		else $error("powered down without cause");
	a_lo_enable: assert property (operating_control_reg[1] [*3] |-> if_lo_out)
		else $error("lo output not on");
	a_lo_disable: assert property (!operating_control_reg[1] |=> !if_lo_out)
		else $error("lo output not off");
	a_turbo_max: assert property (if_turbo |-> if_pump_current == TWRL_PUMP_MAX)
		else $error("turbo without max current");
	a_turbo_needs_fast: assert property (rf_turbo |-> $past(config_reg[5] | config_reg[6]))
		else $error("turbo without fast bit");
	a_pump_programmed: assert property ((!rf_turbo && $stable(config_reg[3:2]))
		[*3] |-> rf_pump_current == config_reg[3:2])
		else $error("pump current not programmed");
	a_hp_bias: assert property ($stable(bias_current_reg[0]) [*3]
		|-> high_power_select == bias_current_reg[0])
		else $error("bias mode wrong");
	c_load: cover property (word_loaded);
	c_down: cover property (device_power_down);
	c_turbo: cover property (rf_turbo);
endmodule : twrl_loader_assertions
bind twrl_loader twrl_loader_assertions twrl_loader_assertions_inst (.clk_sys(clk_sys),
	.sys_rst(sys_rst), .serial_cs_n(serial_cs_n), .power_down_pin_n(power_down_pin_n),
	.rf_main_divider(rf_main_divider), .operating_control_reg(operating_control_reg),
	.config_reg(config_reg), .bias_current_reg(bias_current_reg),
	.device_power_down(device_power_down), .if_lo_out(if_lo_out), .if_turbo(if_turbo),
	.rf_turbo(rf_turbo), .if_pump_current(if_pump_current), .rf_pump_current(rf_pump_current),
	.high_power_select(high_power_select), .word_loaded(word_loaded));

/* dv/testbench.sv */
// testbench: self-checking bench for the three-wire register loader
`timescale 1ns/100ps
module testbench;
	import twrl_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic serial_clk, serial_cs_n, serial_data;
	logic power_down_pin_n = 1'b1;
	logic if_pll_locked = 1'b0;
	logic rf_pll_locked = 1'b0;
	logic [TWRL_RF_MAIN_W-1:0] rf_main_divider;
	logic [TWRL_RF_REF_W-1:0] rf_ref_divider;
	logic [TWRL_IF_MAIN_W-1:0] if_main_divider;
	logic [TWRL_IF_REF_W-1:0] if_ref_divider;
	logic [TWRL_CTRL_W-1:0] operating_control_reg, config_reg, bias_current_reg;
	logic [TWRL_TEST_W-1:0] test_reg;
	logic device_power_down, if_lo_out, if_turbo, rf_turbo, high_power_select, word_loaded;
	logic [TWRL_PUMP_W-1:0] if_pump_current, rf_pump_current;
	wire [5:0] pump = {if_turbo, rf_turbo, if_pump_current, rf_pump_current};
	int err_count = 0;
	int n_checks = 0;
	int loads = 0;
	int wids[8] = '{TWRL_RF_MAIN_W, TWRL_RF_REF_W, TWRL_IF_MAIN_W, TWRL_IF_REF_W,
		TWRL_CTRL_W, TWRL_CTRL_W, TWRL_CTRL_W, TWRL_TEST_W};
	logic [19:0] rsts[8] = '{20'(TWRL_RF_MAIN_RST), 20'(TWRL_RF_REF_RST),
		20'(TWRL_IF_MAIN_RST), 20'(TWRL_IF_REF_RST), 20'(TWRL_OPERATING_CONTROL_REG_RST),
		20'(TWRL_CONFIG_RST), 20'(TWRL_BIAS_RST), 20'(TWRL_TEST_RST)};
	// 50 ns system clock
	always #25 clk_sys = ~clk_sys;
	// count load pulses, each lasts one cycle
	always @(posedge clk_sys) if (word_loaded === 1'b1) loads++;
	twrl_loader twrl_loader_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.serial_clk(serial_clk), .serial_cs_n(serial_cs_n), .serial_data(serial_data),
		.power_down_pin_n(power_down_pin_n), .if_pll_locked(if_pll_locked),
		.rf_pll_locked(rf_pll_locked), .rf_main_divider(rf_main_divider),
		.rf_ref_divider(rf_ref_divider), .if_main_divider(if_main_divider),
		.if_ref_divider(if_ref_divider), .operating_control_reg(operating_control_reg),
		.config_reg(config_reg), .bias_current_reg(bias_current_reg), .test_reg(test_reg),
		.device_power_down(device_power_down), .if_lo_out(if_lo_out), .if_turbo(if_turbo),
		.rf_turbo(rf_turbo), .if_pump_current(if_pump_current),
		.rf_pump_current(rf_pump_current), .high_power_select(high_power_select),
		.word_loaded(word_loaded));
	twrl_host twrl_host_inst (.clk_sys(clk_sys), .serial_clk(serial_clk),
		.serial_cs_n(serial_cs_n), .serial_data(serial_data));
	// compare one value
	task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	// register output for an address
	function automatic logic [19:0] rd(input logic [3:0] a);
		case (a)
			4'h0: return 20'(rf_main_divider);
			4'h1: return 20'(rf_ref_divider);
			4'h2: return 20'(if_main_divider);
			4'h3: return 20'(if_ref_divider);
			4'h4: return 20'(operating_control_reg);
			4'h5: return 20'(config_reg);
			4'h6: return 20'(bias_current_reg);
			default: return 20'(test_reg);
		endcase
	endfunction : rd
	// one word: data in the top 20 bits, address in the low 4
	task automatic wr(input logic [3:0] a, input logic [19:0] d);
		twrl_host_inst.send({d, a});
	endtask : wr
	task automatic t_reset;
		for (int a = 0; a < 8; a++) chk(rd(4'(a)), rsts[a], "reset");
		chk(20'(device_power_down), 20'h0, "up");
		$display("t_reset done");
	endtask : t_reset
	// don't-care bits set (bits 9 and 10 clear for the test register), so a leak shows in the output
	task automatic t_regs;
		int n;
		logic [19:0] d;
		for (int a = 0; a < 8; a++) begin
			n = loads;
			d = 20'hfffff ^ (20'(a) << 8);
			wr(4'(a), d);
			chk(rd(4'(a)), d & ((20'h1 << wids[a]) - 20'h1), "reg");
			chk(20'(loads - n), 20'h1, "pulse");
		end
		$display("t_regs done");
	endtask : t_regs
	task automatic t_unmapped;
		logic [19:0] s[8];
		int n;
		n = loads;
		for (int a = 0; a < 8; a++) s[a] = rd(4'(a));
		wr(4'h8, 20'h12345);
		wr(4'hf, 20'h00000);
		for (int a = 0; a < 8; a++) chk(rd(4'(a)), s[a], "kept");
		chk(20'(loads - n), 20'h0, "no pulse");
		$display("t_unmapped done");
	endtask : t_unmapped
	// shutdown by bit and by pin, with writes made while down
	task automatic t_ctrl;
		wr(4'h4, 20'h00003);
		chk(20'({device_power_down, if_lo_out}), 20'h1, "on");
		wr(4'h4, 20'h00001);
		chk(20'(if_lo_out), 20'h0, "lo off");
		wr(4'h4, 20'h00002);
		chk(20'(device_power_down), 20'h1, "bit down");
		wr(4'h0, 20'h01234);
		wr(4'h4, 20'h00003);
		chk(20'({device_power_down, rf_main_divider}), 20'h01234, "held");
		power_down_pin_n = 1'b0;
		wr(4'h6, 20'h00001);
		chk(20'({device_power_down, high_power_select}), 20'h3, "pin");
		power_down_pin_n = 1'b1;
		wr(4'h6, 20'h00000);
		chk(20'({device_power_down, high_power_select}), 20'h0, "pin up");
		$display("t_ctrl done");
	endtask : t_ctrl
	// each fast-lock bit, then lock reached
	task automatic t_turbo;
		for (int p = 4; p < 7; p++) begin
			wr(4'h5, (20'h1 << p) | 20'h6);
			chk(20'(pump), (p == 4) ? 20'h2d : 20'h1b, "turbo");
			{if_pll_locked, rf_pll_locked} = 2'h3;
			repeat (5) @(posedge clk_sys);
			#1;
			chk(20'(pump), 20'h09, "locked");
			{if_pll_locked, rf_pll_locked} = 2'h0;
		end
		$display("t_turbo done");
	endtask : t_turbo
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done
	// reset, then the scenarios in turn
	initial begin
		repeat (10) @(posedge clk_sys);
		#1;
		sys_rst = 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		t_reset();
		t_regs();
		t_unmapped();
		t_ctrl();
		t_turbo();
		// second reset in mid-run: registers return, no false load at release
		sys_rst = 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		sys_rst = 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		t_reset();
		test_done();
	end
endmodule : testbench
